//--- tcdac_params.svh
`ifndef TCDAC_PARAMS_SVH
`define TCDAC_PARAMS_SVH

// Register indices; byte address on the bus is four times the index
`define TCDAC_IDX_VALUE_CH0 16'hFFF8
`define TCDAC_IDX_VALUE_CH1 16'hFFF9
`define TCDAC_IDX_CONTROL 16'hFFFA
`define TCDAC_ADR_W 18

// Reset values
`define TCDAC_VALUE_RST 8'h00
`define TCDAC_CONTROL_RST 8'h1F
`define TCDAC_CTRL_EN_RST 3'h0
`define TCDAC_RSVD_READ 5'h1F
`define TCDAC_UNMAPPED_READ 32'h0000_0000
`define TCDAC_DATA_PAD 24'h00_0000

// Control register field positions
`define TCDAC_BIT_OE_CH1 7
`define TCDAC_BIT_OE_CH0 6
`define TCDAC_BIT_JOINT 5
`define TCDAC_CTRL_EN_HI 7
`define TCDAC_CTRL_EN_LO 5

// Conversion delay: longest time, rounded down to whole clock cycles
`define TCDAC_CONV_TIME_NS 10000
`define TCDAC_CLK_MHZ 25
`define TCDAC_CONV_CYC ((`TCDAC_CONV_TIME_NS * `TCDAC_CLK_MHZ) / 1000)
`define TCDAC_CNT_W 16

`endif

//--- tcdac_pkg.sv
package tcdac_pkg;

  // Gray codes along idle -> converting -> settled
  typedef enum logic [1:0] {
    TCDAC_IDLE = 2'h0,
    TCDAC_CONV = 2'h1,
    TCDAC_SETTLED = 2'h3
  } tcdac_state_t;

  typedef logic [7:0] tcdac_code_t;

endpackage : tcdac_pkg

//--- tcdac_chan_if.sv
`timescale 1ns/100ps
interface tcdac_chan_if;
  logic convEn;
  logic outEn;
  logic restart;
  tcdac_pkg::tcdac_code_t code;
  tcdac_pkg::tcdac_code_t outCode;
  logic outValid;
  logic outDrive;

  modport ctrl (
    output convEn,
    output outEn,
    output restart,
    output code,
    input outCode,
    input outValid,
    input outDrive
  );

  modport chan (
    input convEn,
    input outEn,
    input restart,
    input code,
    output outCode,
    output outValid,
    output outDrive
  );
endinterface : tcdac_chan_if

//--- tcdac_sync2.sv
`timescale 1ns/100ps
module tcdac_sync2 (
  input wire logic clk,
  input wire logic resetn,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1_ff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1_ff <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1_ff <= asyncIn;
      syncOut <= stage1_ff;
    end
  end
endmodule : tcdac_sync2

//--- tcdac_channel.sv
`timescale 1ns/100ps
`include "tcdac_params.svh"
module tcdac_channel #(
  parameter logic [`TCDAC_CNT_W-1:0] CONV_CYCLES = `TCDAC_CNT_W'(`TCDAC_CONV_CYC)
) (
  input wire logic clk,
  input wire logic resetn,
  tcdac_chan_if.chan ch
);
  tcdac_pkg::tcdac_state_t state_ff;
  logic [`TCDAC_CNT_W-1:0] cnt_ff;
  logic cntDone;

  assign cntDone = (cnt_ff == '0);

  // State: a write or a fresh enable starts a new delay period
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= tcdac_pkg::TCDAC_IDLE;
    end else if (!ch.convEn) begin
      state_ff <= tcdac_pkg::TCDAC_IDLE;
    end else if (ch.restart) begin
      state_ff <= tcdac_pkg::TCDAC_CONV; // [R9]
    end else begin
      unique case (state_ff)
        tcdac_pkg::TCDAC_IDLE: state_ff <= tcdac_pkg::TCDAC_CONV;
        tcdac_pkg::TCDAC_CONV: begin
          if (cntDone) begin
            state_ff <= tcdac_pkg::TCDAC_SETTLED;
          end
        end
        tcdac_pkg::TCDAC_SETTLED: state_ff <= tcdac_pkg::TCDAC_SETTLED; // [R8]
        default: state_ff <= tcdac_pkg::TCDAC_IDLE;
      endcase
    end
  end

  // Delay counter reloads on every start and keeps cycling while enabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else if (!ch.convEn || ch.restart || state_ff == tcdac_pkg::TCDAC_IDLE) begin
      cnt_ff <= CONV_CYCLES - `TCDAC_CNT_W'(1); // [R14]
    end else if (cntDone) begin
      cnt_ff <= CONV_CYCLES - `TCDAC_CNT_W'(1); // [R8]
    end else begin
      cnt_ff <= cnt_ff - `TCDAC_CNT_W'(1);
    end
  end

  // Result latched only at the end of a delay period; held otherwise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ch.outCode <= `TCDAC_VALUE_RST;
    end else if (ch.convEn && !ch.restart && state_ff != tcdac_pkg::TCDAC_IDLE && cntDone) begin
      ch.outCode <= ch.code; // [R10]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ch.outValid <= 1'b0;
    end else if (!ch.convEn || ch.restart) begin
      ch.outValid <= 1'b0;
    end else if (state_ff == tcdac_pkg::TCDAC_CONV && cntDone) begin
      ch.outValid <= 1'b1; // [R14]
    end
  end

  // Pin drive follows the channel's own enable only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ch.outDrive <= 1'b0;
    end else begin
      ch.outDrive <= ch.outEn; // [R6] [R11]
    end
  end
endmodule : tcdac_channel

//--- tcdac_top.sv
// Function
// R1: Value registers clear on reset and standby
// R2: Control resets to pattern 1F, also standby
// R3: Control bits 4..0 ignore writes, read one
// R4: Bit 7 enables ch1 output, bit 6 ch0
// R5: Joint bit makes either enable convert both
// R6: Pin drive depends only on own enable
// R7: Two 8-bit read/write channel value registers
// R8: Enabled channel converts continuously without software
// R9: Writing enabled channel restarts conversion immediately
// R10: Output holds last result until write/disable
// R11: Disabled channel pin released, high impedance
// R12: Joint bit keeps analog section powered
// R13: Software writes value before setting enable
// R14: Valid indication only after conversion delay
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
`include "tcdac_params.svh"
module tcdac_top #(
  parameter logic [`TCDAC_CNT_W-1:0] CONV_CYCLES = `TCDAC_CNT_W'(`TCDAC_CONV_CYC)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`TCDAC_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic standbyIn,
  input wire logic adcStartBit,
  output logic [7:0] analogOutCh0,
  output logic analogOutCh0Oe,
  output logic analogValidCh0,
  output logic [7:0] analogOutCh1,
  output logic analogOutCh1Oe,
  output logic analogValidCh1,
  output logic analogPowerOn
);
  tcdac_pkg::tcdac_code_t analogValueCh0_ff;
  tcdac_pkg::tcdac_code_t analogValueCh1_ff;
  logic [2:0] ctrlEn_ff;
  logic standbySync;
  logic request;
  logic writeNow;
  logic [15:0] regIdx;
  logic selCh0;
  logic selCh1;
  logic selCtrl;
  logic laneLow;
  logic outputEnableCh0;
  logic outputEnableCh1;
  logic jointConvertEnable;
  logic convEnCh0;
  logic convEnCh1;
  logic wrCh0;
  logic wrCh1;
  logic [7:0] controlRead;
  logic [31:0] nxt_readData;

  tcdac_chan_if ch0If ();
  tcdac_chan_if ch1If ();

  // Standby request arrives from outside this clock domain
  tcdac_sync2 u_standby_sync (
    .clk(clk),
    .resetn(resetn),
    .asyncIn(standbyIn),
    .syncOut(standbySync)
  );

  // Bus decode: printed offsets are word indices
  assign request = wb_cyc_i && wb_stb_i;
  assign regIdx = wb_adr_i[`TCDAC_ADR_W-1:2];
  assign selCh0 = (regIdx == `TCDAC_IDX_VALUE_CH0);
  assign selCh1 = (regIdx == `TCDAC_IDX_VALUE_CH1);
  assign selCtrl = (regIdx == `TCDAC_IDX_CONTROL);
  assign laneLow = wb_sel_i[0];
  // Write lands on the edge where the master sees ack
  assign writeNow = request && wb_we_i && wb_ack_o && laneLow;
  assign wrCh0 = writeNow && selCh0;
  assign wrCh1 = writeNow && selCh1;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
    end else begin
      // One wait state, then ack drops so back-to-back cycles re-arm
      wb_ack_o <= request && !wb_ack_o;
    end
  end

  // Channel value registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      analogValueCh0_ff <= `TCDAC_VALUE_RST; // [R1]
    end else if (standbySync) begin
      analogValueCh0_ff <= `TCDAC_VALUE_RST; // [R1]
    end else if (wrCh0) begin
      analogValueCh0_ff <= wb_dat_i[7:0]; // [R7]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      analogValueCh1_ff <= `TCDAC_VALUE_RST; // [R1]
    end else if (standbySync) begin
      analogValueCh1_ff <= `TCDAC_VALUE_RST; // [R1]
    end else if (wrCh1) begin
      analogValueCh1_ff <= wb_dat_i[7:0]; // [R7]
    end
  end

  // Control register: only the three enable bits have storage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrlEn_ff <= `TCDAC_CTRL_EN_RST; // [R2]
    end else if (standbySync) begin
      ctrlEn_ff <= `TCDAC_CTRL_EN_RST; // [R2]
    end else if (writeNow && selCtrl) begin
      ctrlEn_ff <= wb_dat_i[`TCDAC_CTRL_EN_HI:`TCDAC_CTRL_EN_LO]; // [R3]
    end
  end

  assign outputEnableCh1 = ctrlEn_ff[`TCDAC_BIT_OE_CH1 - `TCDAC_CTRL_EN_LO]; // [R4]
  assign outputEnableCh0 = ctrlEn_ff[`TCDAC_BIT_OE_CH0 - `TCDAC_CTRL_EN_LO]; // [R4]
  assign jointConvertEnable = ctrlEn_ff[`TCDAC_BIT_JOINT - `TCDAC_CTRL_EN_LO];
  // Reserved low bits always read back as ones
  assign controlRead = {ctrlEn_ff, `TCDAC_RSVD_READ}; // [R3]

  // Conversion decision table
  always_comb begin
    if (jointConvertEnable) begin
      convEnCh0 = outputEnableCh0 || outputEnableCh1; // [R5]
      convEnCh1 = outputEnableCh0 || outputEnableCh1; // [R5]
    end else begin
      convEnCh0 = outputEnableCh0; // [R5]
      convEnCh1 = outputEnableCh1; // [R5]
    end
  end

  // Read mux; unmapped indices answer with zero
  always_comb begin
    nxt_readData = `TCDAC_UNMAPPED_READ;
    if (selCh0) begin
      nxt_readData = {`TCDAC_DATA_PAD, analogValueCh0_ff}; // [R7]
    end else if (selCh1) begin
      nxt_readData = {`TCDAC_DATA_PAD, analogValueCh1_ff}; // [R7]
    end else if (selCtrl) begin
      nxt_readData = {`TCDAC_DATA_PAD, controlRead};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o <= `TCDAC_UNMAPPED_READ;
    end else if (request && !wb_we_i && !wb_ack_o) begin
      wb_dat_o <= nxt_readData;
    end
  end

  // Channel hookup; a value write only restarts a channel already converting
  assign ch0If.convEn = convEnCh0;
  assign ch0If.outEn = outputEnableCh0; // [R6]
  assign ch0If.code = analogValueCh0_ff;
  assign ch0If.restart = wrCh0 && convEnCh0; // [R9]
  assign ch1If.convEn = convEnCh1;
  assign ch1If.outEn = outputEnableCh1; // [R6]
  assign ch1If.code = analogValueCh1_ff;
  assign ch1If.restart = wrCh1 && convEnCh1; // [R9]

  // Restart pulse coincides with the register update, so the delay period
  // latches the new code at its end rather than the old one.
  tcdac_channel #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_ch0 (
    .clk(clk),
    .resetn(resetn),
    .ch(ch0If.chan)
  );

  tcdac_channel #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_ch1 (
    .clk(clk),
    .resetn(resetn),
    .ch(ch1If.chan)
  );

  // Channel outputs are already flops inside each channel
  assign analogOutCh0 = ch0If.outCode; // [R10]
  assign analogOutCh0Oe = ch0If.outDrive; // [R11]
  assign analogValidCh0 = ch0If.outValid; // [R14]
  assign analogOutCh1 = ch1If.outCode; // [R10]
  assign analogOutCh1Oe = ch1If.outDrive; // [R11]
  assign analogValidCh1 = ch1If.outValid; // [R14]

  // Analog power: joint bit alone is enough to keep it up
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      analogPowerOn <= 1'b0;
    end else begin
      analogPowerOn <= jointConvertEnable || convEnCh0 || convEnCh1 || adcStartBit; // [R12]
    end
  end
endmodule : tcdac_top

//--- tcdac_properties.sv
`timescale 1ns/100ps
`include "tcdac_params.svh"
module tcdac_properties #(
  parameter logic [`TCDAC_CNT_W-1:0] CONV_CYCLES = `TCDAC_CNT_W'(`TCDAC_CONV_CYC)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`TCDAC_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic adcStartBit,
  input wire logic [7:0] analogOutCh0,
  input wire logic analogOutCh0Oe,
  input wire logic analogValidCh0,
  input wire logic analogOutCh1Oe,
  input wire logic analogPowerOn
);
  logic [15:0] lowCnt_ff;
  logic [15:0] idx;
  logic ctrlWr;
  logic oe0Bit;
  logic oe1Bit;
  assign idx = wb_adr_i[17:2];
  assign ctrlWr = wb_ack_o && wb_we_i && wb_sel_i[0] && idx == `TCDAC_IDX_CONTROL;
  assign oe0Bit = wb_dat_i[6];
  assign oe1Bit = wb_dat_i[7];
  // Saturates so a long idle stretch cannot wrap into a false short count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lowCnt_ff <= 16'h0000;
    end else if (analogValidCh0) begin
      lowCnt_ff <= 16'h0000;
    end else if (lowCnt_ff != 16'hFFFF) begin
      lowCnt_ff <= lowCnt_ff + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_oe_ch0: assert property (ctrlWr |-> ##2 analogOutCh0Oe == $past(oe0Bit, 2))
    else $error("channel 0 drive enable wrong");
  a_oe_ch1: assert property (ctrlWr |-> ##2 analogOutCh1Oe == $past(oe1Bit, 2))
    else $error("channel 1 drive enable wrong");
  a_rsvd_ones: assert property (wb_ack_o && !wb_we_i && idx == `TCDAC_IDX_CONTROL
    |-> wb_dat_o[4:0] == 5'h1F && wb_dat_o[31:8] == 24'h000000)
    else $error("control read pattern wrong");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && (idx < `TCDAC_IDX_VALUE_CH0
    || idx > `TCDAC_IDX_CONTROL) |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  a_valid_late: assert property ($rose(analogValidCh0) |-> lowCnt_ff >= CONV_CYCLES)
    else $error("valid before conversion delay");
  a_power_start: assert property (adcStartBit |=> analogPowerOn)
    else $error("power off with start bit set");
  a_power_conv: assert property (analogOutCh0Oe && $past(analogOutCh0Oe) |-> analogPowerOn)
    else $error("power off while converting");
  a_out_hold: assert property ($changed(analogOutCh0)
    |-> analogValidCh0 || analogOutCh0 == 8'h00)
    else $error("output changed without a result");
endmodule : tcdac_properties
bind tcdac_top tcdac_properties #(.CONV_CYCLES(CONV_CYCLES)) u_props (.clk, .resetn,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
  .adcStartBit, .analogOutCh0, .analogOutCh0Oe, .analogValidCh0, .analogOutCh1Oe,
  .analogPowerOn);

//--- tb_top.sv
`timescale 1ns/100ps
`include "tcdac_params.svh"
module tb_top;
  localparam int CC = 4;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic standbyIn = 1'b0;
  logic adcStartBit = 1'b0;
  logic [17:0] wb_adr_i = 18'h00000;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o, rd;
  logic [7:0] analogOutCh0, analogOutCh1, v0, v1, ctl;
  logic wb_ack_o, analogOutCh0Oe, analogValidCh0, analogOutCh1Oe, analogValidCh1;
  logic analogPowerOn;
  int badCount = 0;
  int cmpCount = 0;
  int seed = 52154;
  always #20 clk = ~clk;
  tcdac_top #(.CONV_CYCLES(16'(CC))) u_dut (.clk, .resetn, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .standbyIn,
    .adcStartBit, .analogOutCh0, .analogOutCh0Oe, .analogValidCh0, .analogOutCh1,
    .analogOutCh1Oe, .analogValidCh1, .analogPowerOn);
  task automatic complete_run;
    if (badCount == 0 && cmpCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [15:0] idx, input logic [31:0] dat,
                     input logic [3:0] sel);
    int k;
    k = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    if (k == 20) badCount++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : bus
  // Counts cycles from the launching ack edge until the channel shows a result
  task automatic settle(input logic ch, input int exp);
    int k;
    k = 0;
    @(negedge clk);
    chk(32'(ch ? analogValidCh1 : analogValidCh0), 32'h0);
    while ((ch ? analogValidCh1 : analogValidCh0) !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    chk(32'(k), 32'(exp));
  endtask : settle
  function automatic logic conv(input logic [7:0] c, input logic ch);
    return ch ? (c[7] | (c[5] & c[6])) : (c[6] | (c[5] & c[7]));
  endfunction : conv
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, `TCDAC_IDX_VALUE_CH0, 32'h0, 4'hF);
    chk(rd, 32'h00000000);
    bus(1'b0, `TCDAC_IDX_CONTROL, 32'h0, 4'hF);
    chk(rd, 32'h0000001F);
    bus(1'b0, 16'hFFFB, 32'h0, 4'hF);
    chk(rd, 32'h00000000);
    bus(1'b1, `TCDAC_IDX_CONTROL, 32'h00000000, 4'hF);
    bus(1'b0, `TCDAC_IDX_CONTROL, 32'h0, 4'hF);
    chk(rd, 32'h0000001F);
    repeat (4) begin
      v0 = 8'($random(seed));
      v1 = 8'($random(seed));
      // Codes go in while both enables are still clear
      bus(1'b1, `TCDAC_IDX_VALUE_CH0, {24'h000000, v0}, 4'hF);
      bus(1'b1, `TCDAC_IDX_VALUE_CH1, {24'h000000, v1}, 4'hF);
      bus(1'b1, `TCDAC_IDX_VALUE_CH0, {24'h000000, ~v0}, 4'hE);
      bus(1'b0, `TCDAC_IDX_VALUE_CH0, 32'h0, 4'hF);
      chk(rd, {24'h000000, v0});
      bus(1'b0, `TCDAC_IDX_VALUE_CH1, 32'h0, 4'hF);
      chk(rd, {24'h000000, v1});
    end
    for (int m = 0; m < 8; m++) begin
      ctl = {m[2:0], 5'h00};
      bus(1'b1, `TCDAC_IDX_CONTROL, {24'h000000, ctl}, 4'hF);
      repeat (CC + 4) @(negedge clk);
      chk(32'({analogOutCh1Oe, analogOutCh0Oe}), 32'(ctl[7:6]));
      chk(32'({analogValidCh1, analogValidCh0}), 32'({conv(ctl, 1), conv(ctl, 0)}));
      chk(32'(analogPowerOn), 32'(ctl[7] | ctl[6] | ctl[5]));
      if (analogValidCh0 === 1'b1) chk(32'(analogOutCh0), 32'(v0));
    end
    v0 = v0 ^ (8'($random(seed)) | 8'h01);
    bus(1'b1, `TCDAC_IDX_VALUE_CH0, {24'h000000, v0}, 4'hF);
    settle(1'b0, CC);
    chk(32'(analogOutCh0), 32'(v0));
    bus(1'b1, `TCDAC_IDX_CONTROL, 32'h00000040, 4'hF);
    repeat (CC + 4) @(negedge clk);
    bus(1'b1, `TCDAC_IDX_CONTROL, 32'h000000C0, 4'hF);
    settle(1'b1, CC + 1);
    chk(32'(analogOutCh1), 32'(v1));
    @(posedge clk);
    standbyIn <= 1'b1;
    repeat (4) @(posedge clk);
    standbyIn <= 1'b0;
    repeat (3) @(posedge clk);
    bus(1'b0, `TCDAC_IDX_VALUE_CH1, 32'h0, 4'hF);
    chk(rd, 32'h00000000);
    bus(1'b0, `TCDAC_IDX_CONTROL, 32'h0, 4'hF);
    chk(rd, 32'h0000001F);
    adcStartBit <= 1'b1;
    repeat (3) @(negedge clk);
    chk(32'(analogPowerOn), 32'h1);
    @(posedge clk);
    adcStartBit <= 1'b0;
    repeat (3) @(negedge clk);
    chk(32'(analogPowerOn), 32'h0);
    complete_run();
  end
  initial begin
    #(40 * 5000);
    badCount++;
    complete_run();
  end
endmodule : tb_top
